// [logic/plt_pkg.sv]
package plt_pkg;
    // ****************************************
    // Clock and bit times
    // ****************************************
    localparam int CLK_NS = 50;
    localparam int BIT10_NS = 100;
    localparam int BIT100_NS = 10;
    // ****************************************
    // Timing figures and derived cycle counts
    // ****************************************
    localparam int CRS_OFF_TX_BITS = 24;
    localparam int CRS_OFF_FX_BITS = 14;
    localparam int CRS_OFF_TX_CYC = (CRS_OFF_TX_BITS * BIT100_NS) / CLK_NS;
    localparam int CRS_OFF_FX_CYC = (CRS_OFF_FX_BITS * BIT100_NS) / CLK_NS;
    localparam int RXCLK_HALF_NS = 200;
    localparam int RXCLK_MIN_NS = 160;
    localparam int RXCLK_HALF_CYC = RXCLK_HALF_NS / CLK_NS;
    localparam int RXCLK_MIN_CYC = (RXCLK_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int TX_START_TENTHS = 35;
    localparam int TX_START_CYC = (TX_START_TENTHS * BIT10_NS) / (10 * CLK_NS);
    localparam int EOP_HIGH_NS = 300;
    localparam int EOP_HIGH_CYC = EOP_HIGH_NS / CLK_NS;
    localparam int CRS_ON_NS = 630;
    localparam int CRS_ON_CYC = CRS_ON_NS / CLK_NS;
    localparam int DV_LAT_BITS = 10;
    localparam int DV_LAT_CYC = (DV_LAT_BITS * BIT10_NS) / CLK_NS;
    localparam int RXD_LAT_BITS = 8;
    localparam int CRS_OFF10_NS = 1000;
    localparam int CRS_OFF10_CYC = CRS_OFF10_NS / CLK_NS;
    localparam int PULSE_NS = 100;
    localparam int PULSE_CYC = PULSE_NS / CLK_NS;
    localparam int NLP_MS = 16;
    localparam int NLP_CYC = (NLP_MS * 1000000) / CLK_NS;
    localparam int FLP_CLK_US = 125;
    localparam int FLP_CLK_CYC = (FLP_CLK_US * 1000) / CLK_NS;
    localparam int FLP_DATA_US = 62;
    localparam int FLP_DATA_CYC = (FLP_DATA_US * 1000) / CLK_NS;
    localparam int FLP_BURST_MS = 2;
    localparam int FLP_BURST_CYC = (FLP_BURST_MS * 1000000) / CLK_NS;
    localparam int SD_ON_MS = 1;
    localparam int SD_ON_CYC = (SD_ON_MS * 1000000) / CLK_NS;
    localparam int SD_OFF_US = 250;
    localparam int SD_OFF_CYC = (SD_OFF_US * 1000) / CLK_NS;
    localparam int SD_FAST_TENTHS_US = 13;
    localparam int SD_FAST_CYC = (SD_FAST_TENTHS_US * 100) / CLK_NS;
    localparam int LB_DEAD_US = 550;
    localparam int LB_DEAD_CYC = (LB_DEAD_US * 1000) / CLK_NS;
    localparam int LB_LAT_NS = 240;
    localparam int LB_LAT_CYC = LB_LAT_NS / CLK_NS;
    localparam int FAST_LOSS_BIT = 8;
    localparam int FLP_WORD_W = 16;
    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic [3:0] data;
        logic en;
    } plt_mii_t;
    typedef enum logic [2:0] {
        PLT_LK_IDLE = 3'b001,
        PLT_LK_NLP = 3'b010,
        PLT_LK_FLP = 3'b100
    } plt_link_t;
endpackage

// [logic/plt_edge.sv]
`timescale 1ns/10ps
`default_nettype none
module plt_edge
    import plt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    // ****************************************
    // Two-stage synchroniser and edge finder
    // ****************************************
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else if (ce) begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    assign level = s2_reg;
    assign rise = ce & s2_reg & ~s3_reg;
    assign fall = ce & ~s2_reg & s3_reg;
endmodule
`default_nettype wire

// [logic/plt_timer.sv]
`timescale 1ns/10ps
`default_nettype none
module plt_timer
    import plt_pkg::*;
#(
    parameter int W = 20
)(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic start,
    input wire logic [W-1:0] load,
    output logic busy,
    output logic done
);
    // ****************************************
    // Down counter, one-cycle done pulse
    // ****************************************
    logic [W-1:0] cnt_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg <= '0;
        end else if (ce) begin
            if (start) begin
                cnt_reg <= load;
            end else if (cnt_reg != '0) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
    assign busy = (cnt_reg != '0);
    assign done = ce & ~start & (cnt_reg == {{(W-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

// [logic/plt_phy_timing.sv]
`timescale 1ns/10ps
`default_nettype none
module plt_phy_timing
    import plt_pkg::*;
#(
    parameter int NLP_PERIOD = NLP_CYC,
    parameter int FLP_PERIOD = FLP_CLK_CYC,
    parameter int FLP_DATA = FLP_DATA_CYC,
    parameter int FLP_BURST = FLP_BURST_CYC,
    parameter int SD_ON = SD_ON_CYC,
    parameter int SD_OFF = SD_OFF_CYC,
    parameter int LB_DEAD = LB_DEAD_CYC
)(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic speed_100,
    input wire logic fiber_mode,
    input wire logic loopback,
    input wire logic autoneg_en,
    input wire logic [FLP_WORD_W-1:0] flp_word,
    input wire logic [15:0] signal_detect_config,
    input wire logic tx_clk,
    input wire plt_mii_t tx_in,
    input wire logic line_rx_active,
    input wire logic line_rx_data,
    input wire logic line_rx_sfd,
    input wire logic line_rx_tcode,
    input wire logic line_signal,
    output logic rx_clk,
    output plt_mii_t rx_out,
    output logic crs,
    output logic line_tx_active,
    output logic line_tx_data,
    output logic line_pulse,
    output logic signal_detect
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic txc_lvl, txc_rise, txc_fall;
    logic act_lvl, act_rise, act_fall;
    logic tcode_lvl, tcode_rise, tcode_fall;
    logic sig_lvl, sig_rise, sig_fall;
    logic en_s1_reg, en_s2_reg;
    logic [3:0] d_s1_reg, d_s2_reg;
    logic rxd_s1_reg, rxd_s2_reg, sfd_s1_reg, sfd_s2_reg;
    plt_edge u_txc (.clk(clk), .rst(rst), .ce(ce), .pin(tx_clk),
        .level(txc_lvl), .rise(txc_rise), .fall(txc_fall));
    plt_edge u_act (.clk(clk), .rst(rst), .ce(ce), .pin(line_rx_active),
        .level(act_lvl), .rise(act_rise), .fall(act_fall));
    plt_edge u_tcd (.clk(clk), .rst(rst), .ce(ce), .pin(line_rx_tcode),
        .level(tcode_lvl), .rise(tcode_rise), .fall(tcode_fall));
    plt_edge u_sig (.clk(clk), .rst(rst), .ce(ce), .pin(line_signal),
        .level(sig_lvl), .rise(sig_rise), .fall(sig_fall));
    always_ff @(posedge clk) begin
        if (rst) begin
            en_s1_reg <= 1'b0;
            en_s2_reg <= 1'b0;
            d_s1_reg <= 4'h0;
            d_s2_reg <= 4'h0;
            rxd_s1_reg <= 1'b0;
            rxd_s2_reg <= 1'b0;
            sfd_s1_reg <= 1'b0;
            sfd_s2_reg <= 1'b0;
        end else if (ce) begin
            en_s1_reg <= tx_in.en;
            en_s2_reg <= en_s1_reg;
            d_s1_reg <= tx_in.data;
            d_s2_reg <= d_s1_reg;
            rxd_s1_reg <= line_rx_data;
            rxd_s2_reg <= rxd_s1_reg;
            sfd_s1_reg <= line_rx_sfd;
            sfd_s2_reg <= sfd_s1_reg;
        end
    end
    // ****************************************
    // Transmit sampling and line start/end
    // ****************************************
    plt_mii_t tx_smp_reg;
    logic [3:0] txd_cnt_reg;
    logic [2:0] eop_cnt_reg;
    logic tx_on_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_smp_reg <= '0;
        end else if (ce && txc_fall) begin
            tx_smp_reg <= '{data: d_s2_reg, en: en_s2_reg};
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            txd_cnt_reg <= 4'h0;
            eop_cnt_reg <= 3'h0;
            tx_on_reg <= 1'b0;
            line_tx_active <= 1'b0;
            line_tx_data <= 1'b0;
        end else if (ce) begin
            if (txc_fall && en_s2_reg && !tx_smp_reg.en && !speed_100) begin
                txd_cnt_reg <= 4'(TX_START_CYC);
            end else if (txd_cnt_reg != 4'h0) begin
                txd_cnt_reg <= txd_cnt_reg - 4'h1;
                if (txd_cnt_reg == 4'h1) begin
                    tx_on_reg <= 1'b1;
                    line_tx_active <= 1'b1;
                end
            end
            if (tx_on_reg && txc_fall) begin
                line_tx_data <= tx_smp_reg.data[0];
            end
            if (tx_on_reg && txc_fall && !en_s2_reg) begin
                tx_on_reg <= 1'b0;
                eop_cnt_reg <= 3'(EOP_HIGH_CYC);
                line_tx_data <= 1'b1;
            end else if (eop_cnt_reg != 3'h0) begin
                eop_cnt_reg <= eop_cnt_reg - 3'h1;
                if (eop_cnt_reg == 3'h1) begin
                    line_tx_active <= 1'b0;
                    line_tx_data <= 1'b0;
                end
            end
        end
    end
    // ****************************************
    // Receive clock generation
    // ****************************************
    logic [2:0] rxc_cnt_reg;
    logic [2:0] half_len;
    always_comb begin
        half_len = 3'(RXCLK_HALF_CYC);
        if (rx_clk && act_rise) begin
            half_len = 3'(RXCLK_HALF_CYC + 1);
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_clk <= 1'b0;
            rxc_cnt_reg <= 3'(RXCLK_HALF_CYC);
        end else if (ce) begin
            if (rxc_cnt_reg <= 3'h1 && rxc_cnt_reg >= 3'(RXCLK_MIN_CYC - RXCLK_HALF_CYC + 1)) begin
                rx_clk <= ~rx_clk;
                rxc_cnt_reg <= half_len;
            end else begin
                rxc_cnt_reg <= rxc_cnt_reg - 3'h1;
            end
        end
    end
    wire rxc_rise = ce && !rx_clk && rxc_cnt_reg == 3'h1;
    // ****************************************
    // Carrier sense
    // ****************************************
    logic crs_on_pend;
    logic crs_off_pend;
    logic [5:0] crs_dly_reg;
    plt_timer #(.W(5)) u_crs_on (.clk(clk), .rst(rst), .ce(ce),
        .start(act_rise && !speed_100), .load(5'(CRS_ON_CYC)),
        .busy(crs_on_pend), .done());
    always_ff @(posedge clk) begin
        if (rst) begin
            crs <= 1'b0;
            crs_dly_reg <= 6'h0;
        end else if (ce) begin
            if (speed_100) begin
                if (act_rise) begin
                    crs <= 1'b1;
                end
                if (tcode_rise) begin
                    crs_dly_reg <= fiber_mode ? 6'(CRS_OFF_FX_CYC) : 6'(CRS_OFF_TX_CYC);
                end else if (crs_dly_reg != 6'h0) begin
                    crs_dly_reg <= crs_dly_reg - 6'h1;
                    if (crs_dly_reg == 6'h1) begin
                        crs <= 1'b0;
                    end
                end
            end else begin
                if (act_fall) begin
                    // Less the synchroniser and edge delay
                    crs_dly_reg <= 6'(CRS_OFF10_CYC - 4);
                end else if (crs_dly_reg != 6'h0) begin
                    crs_dly_reg <= crs_dly_reg - 6'h1;
                    if (crs_dly_reg == 6'h1) begin
                        crs <= 1'b0;
                    end
                end else if (act_lvl && !crs_on_pend && !act_rise) begin
                    crs <= 1'b1;
                end
            end
        end
    end
    // ****************************************
    // Receive path, valid and loopback
    // ****************************************
    logic [7:0] rx_pipe_reg;
    logic [4:0] dv_cnt_reg;
    logic dv_arm_reg;
    logic lb_prev_reg;
    logic lb_dead;
    plt_timer #(.W(16)) u_dead (.clk(clk), .rst(rst), .ce(ce),
        .start(loopback && !lb_prev_reg && speed_100), .load(16'(LB_DEAD)),
        .busy(lb_dead), .done());
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_pipe_reg <= 8'h0;
            dv_cnt_reg <= 5'h0;
            dv_arm_reg <= 1'b0;
            lb_prev_reg <= 1'b0;
            rx_out <= '0;
        end else if (ce) begin
            lb_prev_reg <= loopback;
            if (loopback) begin
                if (txc_rise) begin
                    rx_out.en <= en_s2_reg && !lb_dead;
                    rx_out.data <= lb_dead ? 4'h0 : d_s2_reg;
                end
            end else begin
                if (act_rise) begin
                    dv_cnt_reg <= 5'(DV_LAT_CYC - 3);
                end else if (dv_cnt_reg != 5'h0) begin
                    dv_cnt_reg <= dv_cnt_reg - 5'h1;
                    if (dv_cnt_reg == 5'h1) begin
                        dv_arm_reg <= 1'b1;
                    end
                end
                if (!act_lvl && !crs) begin
                    dv_arm_reg <= 1'b0;
                end
                if (sfd_s2_reg || rx_pipe_reg != 8'h0) begin
                    rx_pipe_reg <= {rx_pipe_reg[6:0], rxd_s2_reg};
                end
                if (rxc_rise) begin
                    rx_out.en <= dv_arm_reg;
                    rx_out.data <= rx_pipe_reg[RXD_LAT_BITS-1 -: 4];
                end
            end
        end
    end
    // ****************************************
    // Link pulses
    // ****************************************
    plt_link_t lk_state;
    logic [24:0] per_cnt_reg;
    logic [16:0] slot_cnt_reg;
    logic [5:0] slot_idx_reg;
    logic [1:0] pw_cnt_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            lk_state <= PLT_LK_IDLE;
            per_cnt_reg <= 25'h0;
            slot_cnt_reg <= 17'h0;
            slot_idx_reg <= 6'h0;
            pw_cnt_reg <= 2'h0;
            line_pulse <= 1'b0;
        end else if (ce) begin
            if (pw_cnt_reg != 2'h0) begin
                pw_cnt_reg <= pw_cnt_reg - 2'h1;
            end else begin
                line_pulse <= 1'b0;
            end
            per_cnt_reg <= (per_cnt_reg == 25'(NLP_PERIOD - 1)) ? 25'h0 : per_cnt_reg + 25'h1;
            case (lk_state)
                PLT_LK_IDLE: begin
                    if (per_cnt_reg == 25'h0 && !line_tx_active) begin
                        lk_state <= autoneg_en ? PLT_LK_FLP : PLT_LK_NLP;
                        slot_cnt_reg <= 17'h0;
                        slot_idx_reg <= 6'h0;
                    end
                end
                PLT_LK_NLP: begin
                    line_pulse <= 1'b1;
                    pw_cnt_reg <= 2'(PULSE_CYC - 1);
                    lk_state <= PLT_LK_IDLE;
                end
                PLT_LK_FLP: begin
                    slot_cnt_reg <= slot_cnt_reg + 17'h1;
                    if (slot_cnt_reg == 17'h0) begin
                        line_pulse <= 1'b1;
                        pw_cnt_reg <= 2'(PULSE_CYC - 1);
                    end else if (slot_cnt_reg == 17'(FLP_DATA)
                                 && slot_idx_reg < 6'(FLP_WORD_W)
                                 && flp_word[slot_idx_reg[3:0]]) begin
                        line_pulse <= 1'b1;
                        pw_cnt_reg <= 2'(PULSE_CYC - 1);
                    end
                    if (slot_cnt_reg == 17'(FLP_PERIOD - 1)) begin
                        slot_cnt_reg <= 17'h0;
                        slot_idx_reg <= slot_idx_reg + 6'h1;
                        if (slot_idx_reg == 6'(FLP_WORD_W)) begin
                            lk_state <= PLT_LK_IDLE;
                        end
                    end
                    if (per_cnt_reg == 25'(FLP_BURST + FLP_PERIOD)) begin
                        lk_state <= PLT_LK_IDLE;
                    end
                end
                default: lk_state <= PLT_LK_IDLE;
            endcase
        end
    end
    // ****************************************
    // Signal detect
    // ****************************************
    logic [15:0] sd_cnt_reg;
    wire fast_loss = signal_detect_config[FAST_LOSS_BIT];
    always_ff @(posedge clk) begin
        if (rst) begin
            signal_detect <= 1'b0;
            sd_cnt_reg <= 16'h0;
        end else if (ce) begin
            if (sig_lvl != signal_detect) begin
                if (sd_cnt_reg == 16'h0) begin
                    signal_detect <= sig_lvl;
                end else begin
                    sd_cnt_reg <= sd_cnt_reg - 16'h1;
                end
            end else begin
                sd_cnt_reg <= signal_detect ?
                    (fast_loss ? 16'(SD_FAST_CYC) : 16'(SD_OFF)) : 16'(SD_ON);
            end
        end
    end
endmodule
`default_nettype wire

// [tb/plt_mac_model.sv]
`timescale 1ns/10ps
`default_nettype none
module plt_mac_model
    import plt_pkg::*;
(
    input wire logic send,
    output logic tx_clk,
    output plt_mii_t tx_in
);
    // ********
    // Free running transmit clock, 200 ns a phase
    // ********
    initial begin
        tx_clk = 1'b0;
        tx_in = '0;
        #13;
        forever #200 tx_clk = ~tx_clk;
    end
    // Nibbles count up in a frame; idle data inverts on every clock, alternating the last nibble and its inverse
    always @(posedge tx_clk) begin
        tx_in.en <= send;
        tx_in.data <= send ? tx_in.data + 4'h1 : ~tx_in.data;
    end
endmodule
`default_nettype wire

// [tb/plt_phy_timing_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module plt_phy_timing_asserts
    import plt_pkg::*;
#(
    parameter int SD_ON = SD_ON_CYC
)(
    input wire logic clk,
    input wire logic rst,
    input wire logic speed_100,
    input wire logic fiber_mode,
    input wire logic loopback,
    input wire logic [15:0] signal_detect_config,
    input wire logic line_rx_active,
    input wire logic line_rx_tcode,
    input wire logic line_signal,
    input wire logic rx_clk,
    input wire plt_mii_t rx_out,
    input wire logic crs,
    input wire logic line_tx_active,
    input wire logic line_tx_data,
    input wire logic line_pulse,
    input wire logic signal_detect
);
    localparam int SD_ON_MAX = SD_ON + 3;
    localparam int SD_FAST_MAX = SD_FAST_CYC + 4;
    localparam int CRS_MAX = CRS_OFF10_CYC + 3;
    localparam int T_OFF_MAX = CRS_OFF_TX_CYC + 4;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ********
    // Checks
    // ********
    rx_high_min_a: assert property ($rose(rx_clk) |=> rx_clk [*3])
        else $error("receive clock high phase too short");
    rx_low_min_a: assert property ($fell(rx_clk) |=> !rx_clk [*3])
        else $error("receive clock low phase too short");
    rx_edge_a: assert property (!speed_100 && $changed(rx_out) |-> $rose(rx_clk))
        else $error("receive data changed off the clock rise");
    pulse_width_a: assert property ($rose(line_pulse) |=> line_pulse ##1 !line_pulse)
        else $error("link pulse width wrong");
    eop_high_a: assert property ($fell(line_tx_active) |-> $past(line_tx_data) && $past(line_tx_data, 5))
        else $error("end of packet high time too short");
    crs_on_a: assert property (!speed_100 && !loopback && $rose(line_rx_active) |-> ##[1:CRS_MAX] crs)
        else $error("carrier sense late");
    crs_off_a: assert property (!speed_100 && $fell(line_rx_active) |-> ##[1:CRS_MAX] !crs)
        else $error("carrier sense stays too long");
    crs_t_off_a: assert property (speed_100 && !fiber_mode && line_rx_tcode |-> ##[1:T_OFF_MAX] !crs)
        else $error("carrier sense not dropped after end code");
    sd_on_a: assert property (speed_100 && $rose(line_signal) |-> ##[1:SD_ON_MAX] signal_detect)
        else $error("signal detect late");
    sd_fast_a: assert property (speed_100 && signal_detect_config[FAST_LOSS_BIT] && $fell(line_signal)
        |-> ##[1:SD_FAST_MAX] !signal_detect)
        else $error("fast signal loss late");
    sd_hold_a: assert property (speed_100 && !signal_detect_config[FAST_LOSS_BIT] && $fell(line_signal)
        && signal_detect |=> signal_detect [*8])
        else $error("signal detect removed too early");
    lb_dead_a: assert property (speed_100 && $rose(loopback) |=> !rx_out.en [*8])
        else $error("receive data during loopback dead time");
    cover property ($rose(line_pulse));
    cover property ($fell(signal_detect));
    cover property ($rose(rx_out.en));
endmodule
bind plt_phy_timing plt_phy_timing_asserts #(.SD_ON(SD_ON)) plt_phy_timing_asserts_inst (
    .clk, .rst, .speed_100, .fiber_mode, .loopback, .signal_detect_config, .line_rx_active,
    .line_rx_tcode, .line_signal, .rx_clk, .rx_out, .crs, .line_tx_active, .line_tx_data,
    .line_pulse, .signal_detect
);
`default_nettype wire

// [tb/plt_phy_timing_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module plt_phy_timing_tb import plt_pkg::*;;
    localparam int NLP_P = 2000;
    localparam int FLP_P = 40;
    localparam int FLP_D = 20;
    localparam int FLP_B = 640;
    localparam int SD_ON_P = 50;
    localparam int SD_OFF_P = 100;
    localparam int LB_DEAD_P = 20;
    localparam int LIMIT = 40000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic speed_100 = 1'b0;
    logic fiber_mode = 1'b0;
    logic loopback = 1'b0;
    logic autoneg_en = 1'b0;
    logic [FLP_WORD_W-1:0] flp_word = '0;
    logic [15:0] sd_cfg = '0;
    logic line_rx_active = 1'b0;
    logic line_rx_data = 1'b0;
    logic line_rx_tcode = 1'b0;
    logic line_rx_sfd = 1'b0;
    logic line_signal = 1'b0;
    logic send = 1'b0;
    logic lp_d = 1'b0;
    logic tx_clk, rx_clk, crs, line_tx_active, line_tx_data, line_pulse, signal_detect;
    plt_mii_t tx_in;
    plt_mii_t rx_out;
    logic [6:0] outs;
    int mismatches = 0;
    int check_count = 0;
    int tick = 0;
    int pt[$];
    assign outs = {signal_detect, line_pulse, line_tx_data, line_tx_active, crs, rx_out.en, rx_clk};
    always #25 clk = ~clk;
    plt_mac_model plt_mac_model_inst (.send, .tx_clk, .tx_in);
    plt_phy_timing #(.NLP_PERIOD(NLP_P), .FLP_PERIOD(FLP_P), .FLP_DATA(FLP_D), .FLP_BURST(FLP_B),
        .SD_ON(SD_ON_P), .SD_OFF(SD_OFF_P), .LB_DEAD(LB_DEAD_P)) plt_phy_timing_inst (
        .clk, .rst, .ce(1'b1), .speed_100, .fiber_mode, .loopback, .autoneg_en, .flp_word,
        .signal_detect_config(sd_cfg), .tx_clk, .tx_in, .line_rx_active, .line_rx_data,
        .line_rx_sfd, .line_rx_tcode, .line_signal, .rx_clk, .rx_out, .crs,
        .line_tx_active, .line_tx_data, .line_pulse, .signal_detect
    );
    // ********
    // Line bits, pulse capture and hang guard
    // ********
    always @(posedge clk) begin
        tick <= tick + 1;
        line_rx_data <= line_rx_active & tick[1];
        if (tick == LIMIT) begin
            mismatches++;
            end_sim();
        end
    end
    always @(negedge clk) begin
        lp_d <= line_pulse;
        if (line_pulse === 1'b1 && lp_d === 1'b0) pt.push_back(tick);
    end
    // ********
    // Helpers
    // ********
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic rng(input int n, input int lo, input int hi);
        chk((n >= lo && n <= hi) ? lo : n, lo);
    endtask
    task automatic lat(input int b, input logic v, output int n);
        n = 0;
        while (outs[b] !== v && n < 5000) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask
    // ********
    // Scenarios
    // ********
    task automatic t_tx();
        int n;
        int h;
        for (int f = 3; f < 5; f++) begin
            cyc(1);
            send <= 1'b1;
            @(negedge tx_clk iff tx_in.en === 1'b1);
            lat(3, 1'b1, n);
            rng(n, TX_START_CYC + 2, TX_START_CYC + 4);
            repeat (f) @(posedge tx_clk);
            cyc(1);
            send <= 1'b0;
            h = 0;
            @(negedge tx_clk iff tx_in.en === 1'b0);
            for (int k = 0; k < 200 && line_tx_active === 1'b1; k++) begin
                h = (line_tx_data === 1'b1) ? h + 1 : 0;
                @(negedge clk);
            end
            rng(h, EOP_HIGH_CYC - 1, 60);
        end
        $display("transmit test done");
    endtask
    task automatic t_rx10();
        int n;
        int m;
        cyc(1);
        line_rx_active <= 1'b1;
        lat(2, 1'b1, n);
        rng(n, CRS_ON_CYC, 1000 / CLK_NS);
        lat(1, 1'b1, m);
        rng(n + m, DV_LAT_CYC, DV_LAT_CYC + 2 * RXCLK_HALF_CYC);
        line_rx_sfd <= 1'b1;
        cyc(1);
        line_rx_sfd <= 1'b0;
        cyc(30);
        chk(rx_out.data != 4'h0, 1'b1);
        cyc(9);
        line_rx_active <= 1'b0;
        lat(2, 1'b0, n);
        rng(n, 1, CRS_OFF10_CYC + 3);
        $display("receive test done");
    endtask
    task automatic t_crs100();
        int n;
        int e;
        for (int f = 0; f < 2; f++) begin
            cyc(1);
            speed_100 <= 1'b1;
            fiber_mode <= f[0];
            line_rx_active <= 1'b1;
            e = f ? CRS_OFF_FX_CYC : CRS_OFF_TX_CYC;
            lat(2, 1'b1, n);
            cyc(10);
            line_rx_tcode <= 1'b1;
            cyc(1);
            line_rx_tcode <= 1'b0;
            lat(2, 1'b0, n);
            rng(n, e, e + 4);
            cyc(1);
            line_rx_active <= 1'b0;
        end
        $display("carrier off test done");
    endtask
    task automatic t_pulse();
        int i;
        int pp;
        int g;
        cyc(1);
        speed_100 <= 1'b0;
        pt.delete();
        cyc(2 * NLP_P + 10);
        chk(pt[1] - pt[0], NLP_P);
        for (int w = 0; w < 2; w++) begin
            autoneg_en <= 1'b1;
            flp_word <= w ? 16'hFFFF : 16'h0000;
            pp = w ? 33 : 17;
            g = w ? FLP_D : FLP_P;
            pt.delete();
            cyc(4 * NLP_P);
            i = 1;
            while (i < pt.size() - 1 && pt[i] - pt[i - 1] < 2 * FLP_P) begin
                i++;
            end
            for (int j = 0; j < pp - 1; j++) chk(pt[i + j + 1] - pt[i + j], g);
            chk(pt[i + pp - 1] - pt[i], FLP_B);
            chk(pt[i + pp] - pt[i], NLP_P);
        end
        autoneg_en <= 1'b0;
        $display("link pulse test done");
    endtask
    task automatic t_sd();
        int n;
        for (int f = 0; f < 2; f++) begin
            cyc(1);
            speed_100 <= 1'b1;
            sd_cfg <= f ? 16'h0100 : 16'hFEFF;
            line_signal <= 1'b1;
            lat(6, 1'b1, n);
            rng(n, 1, SD_ON_P + 4);
            cyc(1);
            line_signal <= 1'b0;
            lat(6, 1'b0, n);
            if (f) rng(n, SD_FAST_CYC, SD_FAST_CYC + 4);
            else rng(n, SD_OFF_P, SD_OFF_P * 300 / 250 + 4);
        end
        $display("signal detect test done");
    endtask
    task automatic t_lb();
        int n;
        logic bad;
        cyc(1);
        speed_100 <= 1'b1;
        loopback <= 1'b1;
        send <= 1'b1;
        bad = 1'b0;
        repeat (LB_DEAD_P - 4) begin
            @(negedge clk);
            bad = bad | rx_out.en;
        end
        chk(bad, 1'b0);
        cyc(LB_DEAD_P + 10);
        send <= 1'b0;
        cyc(30);
        send <= 1'b1;
        @(posedge tx_clk iff tx_in.en === 1'b0);
        @(posedge tx_clk);
        lat(1, 1'b1, n);
        rng(n, 0, LB_LAT_CYC);
        cyc(1);
        send <= 1'b0;
        loopback <= 1'b0;
        $display("loopback test done");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        cyc(16);
        chk({rx_out, outs[6:1]}, '0);
        rst <= 1'b0;
        cyc(8);
        t_tx();
        t_rx10();
        t_crs100();
        t_pulse();
        t_sd();
        t_lb();
        end_sim();
    end
endmodule
`default_nettype wire
